// ==== rtl/spi_port.sv ====
// serial port core with its documented silicon behaviour
// Behaviour
// - slave enable may raise false receive ready
// - disable command ignored while in slave mode
// - hold-select with fault check on blocks transfers
// - disabling leaves transmit empty flag unchanged
// - writes while disabled dropped, empty flag kept
// - dma words after disable are lost silently
// - slave mode reports no transmit underrun
`timescale 1ns/10ps
module spi_port #(
	parameter int SCK_HALF = spi_port_pkg::SCK_HALF  // master sck half period
) (
	// core clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// control strobes
	input  wire logic       enable_cmd,
	input  wire logic       disable_cmd,
	input  wire logic       soft_reset_bit,
	// mode register write
	input  wire logic       mode_write,
	input  wire logic       master_mode_in,
	input  wire logic       mode_fault_check_disable_in,
	// select 0 configuration write
	input  wire logic       select0_write,
	input  wire logic       clock_idle_polarity_in,
	input  wire logic       sample_phase_in,
	input  wire logic       hold_select_after_transfer_in,
	// transmit data write by software
	input  wire logic       tx_write,
	input  wire logic [7:0] tx_data,
	// peripheral dma channel write
	input  wire logic       dma_valid,
	input  wire logic [7:0] dma_data,
	output logic            dma_ready,
	// receive holding register read
	input  wire logic       rx_read,
	output logic [7:0]      receive_holding_register,
	// status
	output logic            receive_ready_flag,
	output logic            transmit_empty_flag,
	output logic            port_enabled,
	output logic            master_mode,
	output logic            clock_idle_polarity,
	// master pins
	output logic            sck_out,
	output logic            select0_n_out,
	output logic            mosi_out,
	input  wire logic       miso_in,
	// slave pins
	input  wire logic       link_clk,
	input  wire logic       select_in_n,
	input  wire logic       mosi_in,
	output logic            miso_slave_out,
	output logic            miso_oe_n
);
	////////////////////////////////////////////////////////////////
	// state
	logic       en_reg, en_next;          // port enabled
	logic       mstr_reg, mstr_next;      // master mode selected
	logic       mfd_reg, mfd_next;        // mode fault check disabled
	logic       pol_reg, pol_next;        // clock idle polarity
	logic       pha_reg, pha_next;        // sample phase
	logic       hold_reg, hold_next;      // hold select after transfer
	logic [7:0] tdr_reg, tdr_next;        // transmit data register
	logic       tde_reg, tde_next;        // transmit empty flag
	logic [7:0] rhr_reg, rhr_next;        // receive holding register
	logic       rdy_reg, rdy_next;        // receive ready flag
	logic       arm_reg, arm_next;        // false ready still possible
	logic       polx_reg, polx_next;      // polarity moved away once
	spi_port_pkg::master_state_t st_reg, st_next;  // master engine state
	logic [2:0] bit_reg, bit_next;        // master bit index
	logic [7:0] msh_reg, msh_next;        // master shift register
	logic [7:0] div_reg, div_next;        // sck half period counter
	logic       sck_reg, sck_next;        // master sck level
	logic       cs_reg, cs_next;          // select 0 active
	logic       seen_reg, seen_next;      // last slave toggle seen

	// crossings and helpers
	logic       miso_s;                   // synchronised master input
	logic       done_s;                   // synchronised slave toggle
	logic       sel_s_n;                  // synchronised slave select
	logic       slave_toggle;             // raw toggle from link domain
	logic       link_rst_n;               // frame reset for link side
	logic [7:0] slave_rx;                 // slave word, stable on toggle
	logic       wr_go;                    // a data write arrives
	logic [7:0] wr_word;                  // the written word
	logic       slave_done;               // slave character finished
	logic       stall;                    // hold and fault check clash
	logic       half_end;                 // sck half period elapsed

	////////////////////////////////////////////////////////////////
	// clock domain crossings
	bit_sync u_miso_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (miso_in),
		.q       (miso_s)
	);

	bit_sync u_done_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (slave_toggle),
		.q       (done_s)
	);

	bit_sync u_sel_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (select_in_n),
		.q       (sel_s_n)
	);

	// link shifter runs only while selected in enabled slave mode
	assign link_rst_n = reset_n & ~select_in_n & en_reg & ~mstr_reg;

	spi_slave_link u_link (
		.link_clk    (link_clk),
		.reset_n     (reset_n),
		.frame_rst_n (link_rst_n),
		.mosi_in     (mosi_in),
		.miso_out    (miso_slave_out),
		.tx_word     (tdr_reg),
		.rx_word     (slave_rx),
		.done_toggle (slave_toggle)
	);

	////////////////////////////////////////////////////////////////
	// helper terms
	assign wr_go      = tx_write | dma_valid;
	assign wr_word    = tx_write ? tx_data : dma_data;
	assign slave_done = (done_s != seen_reg);
	assign stall      = hold_reg & ~mfd_reg;
	assign half_end   = (div_reg == 8'(SCK_HALF - 1));
	// dma accepted unless tx_write is high; words lost if disabled
	assign dma_ready  = ~tx_write;

	////////////////////////////////////////////////////////////////
	// next state of the whole core
	always_comb begin
		en_next   = en_reg;
		mstr_next = mstr_reg;
		mfd_next  = mfd_reg;
		pol_next  = pol_reg;
		pha_next  = pha_reg;
		hold_next = hold_reg;
		tdr_next  = tdr_reg;
		tde_next  = tde_reg;
		rhr_next  = rhr_reg;
		rdy_next  = rdy_reg;
		arm_next  = arm_reg;
		polx_next = polx_reg;
		st_next   = st_reg;
		bit_next  = bit_reg;
		msh_next  = msh_reg;
		div_next  = half_end ? 8'h00 : div_reg + 8'h01;
		sck_next  = sck_reg;
		cs_next   = cs_reg;
		seen_next = done_s;

		// configuration writes
		if (mode_write) begin
			mstr_next = master_mode_in;
			mfd_next  = mode_fault_check_disable_in;
		end
		if (select0_write) begin
			pol_next  = clock_idle_polarity_in;
			pha_next  = sample_phase_in;
			hold_next = hold_select_after_transfer_in;
			// polarity moved while armed: first half of the fix
			if (arm_reg && en_reg && (clock_idle_polarity_in != pol_reg)) begin
				if (polx_reg) begin
					arm_next  = 1'h0;
					polx_next = 1'h0;
				end else begin
					polx_next = 1'h1;
				end
			end
		end

		// enable command; disable comes after the engine
		if (enable_cmd && !en_reg) begin
			en_next = 1'h1;
			if (!mstr_reg) begin
				arm_next  = 1'h1;
				polx_next = 1'h0;
			end
		end
		// transmit data writes, dropped while disabled
		if (wr_go && en_reg) begin
			tdr_next = wr_word;
			tde_next = 1'h0;
		end

		// receive read clears ready
		if (rx_read) begin
			rdy_next = 1'h0;
		end

		// false ready from enabling in slave mode
		if (arm_reg && en_reg && !mstr_reg && !sel_s_n) begin
			rdy_next = 1'h1;
		end

		// slave character finished: no underrun report if empty
		if (slave_done && !mstr_reg) begin
			rhr_next = slave_rx;
			rdy_next = 1'h1;
			tde_next = 1'h1;
			arm_next = 1'h0;
		end

		// master shift engine
		case (st_reg)
			spi_port_pkg::ST_IDLE,
			spi_port_pkg::ST_HOLD: begin
				sck_next = pol_reg;
				// a held select drops once hold select after transfer is cleared
				if (st_reg == spi_port_pkg::ST_HOLD && !hold_reg) begin
					cs_next = 1'h0;
					st_next = spi_port_pkg::ST_IDLE;
				end
				// start only when not blocked by the clash
				if (en_reg && mstr_reg && !tde_reg && !stall) begin
					st_next  = spi_port_pkg::ST_LEAD;
					msh_next = tdr_reg;
					tde_next = 1'h1;
					bit_next = 3'h0;
					cs_next  = 1'h1;
					div_next = 8'h00;
				end
			end
			spi_port_pkg::ST_LEAD: begin
				if (half_end) begin
					sck_next = ~sck_reg;
					st_next  = spi_port_pkg::ST_TRAIL;
					// sample on leading edge when phase is zero
					if (!pha_reg) begin
						msh_next = {msh_reg[6:0], miso_s};
					end
				end
			end
			spi_port_pkg::ST_TRAIL: begin
				if (half_end) begin
					sck_next = ~sck_reg;
					if (pha_reg) begin
						msh_next = {msh_reg[6:0], miso_s};
					end
					if (bit_reg == spi_port_pkg::LAST_BIT) begin
						rhr_next = pha_reg ? {msh_reg[6:0], miso_s} : msh_reg;
						rdy_next = 1'h1;
						cs_next  = hold_reg;
						st_next  = hold_reg ? spi_port_pkg::ST_HOLD
						                    : spi_port_pkg::ST_IDLE;
					end else begin
						bit_next = bit_reg + 3'h1;
						st_next  = spi_port_pkg::ST_LEAD;
					end
				end
			end
			default: begin
				st_next = spi_port_pkg::ST_IDLE;
			end
		endcase

		// disable only acts in master mode; empty flag untouched
		// placed after the engine so a stop in mid-word really stops it
		if (disable_cmd && mstr_reg) begin
			en_next  = 1'h0;
			st_next  = spi_port_pkg::ST_IDLE;
			cs_next  = 1'h0;
			sck_next = pol_reg;
		end

		// soft reset returns all but shifter, bit index, divider and seen toggle, port disabled
		if (soft_reset_bit) begin
			en_next   = spi_port_pkg::RST_BIT;
			mstr_next = spi_port_pkg::RST_BIT;
			mfd_next  = spi_port_pkg::RST_BIT;
			pol_next  = spi_port_pkg::RST_BIT;
			pha_next  = spi_port_pkg::RST_BIT;
			hold_next = spi_port_pkg::RST_BIT;
			tdr_next  = spi_port_pkg::RST_WORD;
			tde_next  = spi_port_pkg::RST_EMPTY;
			rhr_next  = spi_port_pkg::RST_WORD;
			rdy_next  = spi_port_pkg::RST_BIT;
			arm_next  = spi_port_pkg::RST_BIT;
			polx_next = spi_port_pkg::RST_BIT;
			st_next   = spi_port_pkg::ST_IDLE;
			sck_next  = spi_port_pkg::RST_BIT;
			cs_next   = spi_port_pkg::RST_BIT;
		end
	end

	////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_reg   <= spi_port_pkg::RST_BIT;
			mstr_reg <= spi_port_pkg::RST_BIT;
			mfd_reg  <= spi_port_pkg::RST_BIT;
			pol_reg  <= spi_port_pkg::RST_BIT;
			pha_reg  <= spi_port_pkg::RST_BIT;
			hold_reg <= spi_port_pkg::RST_BIT;
			tdr_reg  <= spi_port_pkg::RST_WORD;
			tde_reg  <= spi_port_pkg::RST_EMPTY;
			rhr_reg  <= spi_port_pkg::RST_WORD;
			rdy_reg  <= spi_port_pkg::RST_BIT;
			arm_reg  <= spi_port_pkg::RST_BIT;
			polx_reg <= spi_port_pkg::RST_BIT;
			st_reg   <= spi_port_pkg::ST_IDLE;
			bit_reg  <= 3'h0;
			msh_reg  <= spi_port_pkg::RST_WORD;
			div_reg  <= 8'h00;
			sck_reg  <= spi_port_pkg::RST_BIT;
			cs_reg   <= spi_port_pkg::RST_BIT;
			seen_reg <= spi_port_pkg::RST_BIT;
		end else begin
			en_reg   <= en_next;
			mstr_reg <= mstr_next;
			mfd_reg  <= mfd_next;
			pol_reg  <= pol_next;
			pha_reg  <= pha_next;
			hold_reg <= hold_next;
			tdr_reg  <= tdr_next;
			tde_reg  <= tde_next;
			rhr_reg  <= rhr_next;
			rdy_reg  <= rdy_next;
			arm_reg  <= arm_next;
			polx_reg <= polx_next;
			st_reg   <= st_next;
			bit_reg  <= bit_next;
			msh_reg  <= msh_next;
			div_reg  <= div_next;
			sck_reg  <= sck_next;
			cs_reg   <= cs_next;
			seen_reg <= seen_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign receive_holding_register = rhr_reg;
	assign receive_ready_flag       = rdy_reg;
	assign transmit_empty_flag      = tde_reg;
	assign port_enabled             = en_reg;
	assign master_mode              = mstr_reg;
	assign clock_idle_polarity      = pol_reg;
	assign sck_out                  = sck_reg;
	assign select0_n_out            = ~cs_reg;
	assign mosi_out                 = msh_reg[7];
	// slave drives its output only while selected; raw select so the
	// first bit is on the line before the first link edge
	assign miso_oe_n                = ~(en_reg & ~mstr_reg & ~select_in_n);
endmodule : spi_port

// ==== rtl/spi_port_pkg.sv ====
// constants and types shared by the serial port design files
package spi_port_pkg;
	localparam int          WORD_BITS   = 8;      // character width
	localparam int          CNT_W       = 3;      // bit counter width
	localparam int          SCK_HALF    = 2;      // clk cycles per sck half period
	localparam logic        RST_BIT     = 1'h0;   // reset value of flags/config
	localparam logic        RST_EMPTY   = 1'h1;   // transmit empty after reset
	localparam logic [7:0]  RST_WORD    = 8'h00;  // reset value of data words
	localparam logic [2:0]  LAST_BIT    = 3'h7;   // index of final bit
	// master shift engine states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LEAD  = 2'b01,
		ST_TRAIL = 2'b10,
		ST_HOLD  = 2'b11
	} master_state_t;
endpackage : spi_port_pkg

// ==== rtl/bit_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/10ps
module bit_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// level in and synchronised level out
	input  wire logic d,
	output logic      q
);
	logic meta_reg;  // first stage, read only by second stage
	logic q_reg;     // second stage

	// both stages register every edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= spi_port_pkg::RST_BIT;
			q_reg    <= spi_port_pkg::RST_BIT;
		end else begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule : bit_sync

// ==== rtl/spi_slave_link.sv ====
// slave-mode shifter running on the link clock
`timescale 1ns/10ps
module spi_slave_link (
	// link clock, core reset and frame reset (select released)
	input  wire logic       link_clk,
	input  wire logic       reset_n,
	input  wire logic       frame_rst_n,
	// serial pins
	input  wire logic       mosi_in,
	output logic            miso_out,
	// word exchange with the core domain
	input  wire logic [7:0] tx_word,
	output logic [7:0]      rx_word,
	output logic            done_toggle
);
	logic [7:0] rx_shift_reg, rx_shift_next;  // incoming bits
	logic [7:0] tx_shift_reg, tx_shift_next;  // outgoing bits
	logic [2:0] cnt_reg, cnt_next;            // bits taken in this frame
	logic [7:0] rx_word_reg, rx_word_next;    // last whole character
	logic       done_reg, done_next;          // flips per character

	// next values for one sample edge
	always_comb begin
		rx_shift_next = {rx_shift_reg[6:0], mosi_in};
		tx_shift_next = (cnt_reg == 3'h0) ? {tx_word[6:0], 1'h0}
		                                  : {tx_shift_reg[6:0], 1'h0};
		cnt_next      = cnt_reg + 3'h1;
		rx_word_next  = rx_word_reg;
		done_next     = done_reg;
		// character complete on the eighth sample
		if (cnt_reg == spi_port_pkg::LAST_BIT) begin
			rx_word_next = {rx_shift_reg[6:0], mosi_in};
			done_next    = ~done_reg;
		end
	end

	// shift state cleared when the frame ends, word and toggle kept
	always_ff @(posedge link_clk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rx_shift_reg <= spi_port_pkg::RST_WORD;
			tx_shift_reg <= spi_port_pkg::RST_WORD;
			cnt_reg      <= 3'h0;
		end else begin
			rx_shift_reg <= rx_shift_next;
			tx_shift_reg <= tx_shift_next;
			cnt_reg      <= cnt_next;
		end
	end

	// word and toggle live until the core is reset; a frame end must not flip the toggle
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_word_reg <= spi_port_pkg::RST_WORD;
			done_reg    <= spi_port_pkg::RST_BIT;
		end else begin
			rx_word_reg <= rx_word_next;
			done_reg    <= done_next;
		end
	end

	// first bit straight from the word, later bits from the shifter
	assign miso_out    = (cnt_reg == 3'h0) ? tx_word[7] : tx_shift_reg[7];
	assign rx_word     = rx_word_reg;
	assign done_toggle = done_reg;
endmodule : spi_slave_link

// ==== verif/spi_port_checker.sv ====
// assertions on the serial port top-level ports
`timescale 1ns/10ps
module spi_port_checker (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// strobes and config writes
	input wire logic enable_cmd,
	input wire logic disable_cmd,
	input wire logic soft_reset_bit,
	input wire logic mode_write,
	input wire logic mode_fault_check_disable_in,
	input wire logic select0_write,
	input wire logic hold_select_after_transfer_in,
	input wire logic tx_write,
	input wire logic dma_valid,
	input wire logic dma_ready,
	// status and pins
	input wire logic receive_ready_flag,
	input wire logic transmit_empty_flag,
	input wire logic port_enabled,
	input wire logic master_mode,
	input wire logic clock_idle_polarity,
	input wire logic select0_n_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////
	logic hold_reg, hold_next; // shadow of hold-select setting
	logic fdis_reg, fdis_next; // shadow of fault check disable
	// next shadow values, soft reset first
	always_comb begin
		hold_next = hold_reg;
		fdis_next = fdis_reg;
		if (soft_reset_bit) begin
			hold_next = 1'h0;
			fdis_next = 1'h0;
		end else begin
			if (select0_write) hold_next = hold_select_after_transfer_in;
			if (mode_write) fdis_next = mode_fault_check_disable_in;
		end
	end
	// shadow registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_reg <= 1'h0;
			fdis_reg <= 1'h0;
		end else begin
			hold_reg <= hold_next;
			fdis_reg <= fdis_next;
		end
	end
	////////////////////////////////
	a_master_ready_src: assert property ($rose(receive_ready_flag) && master_mode
		|-> !select0_n_out || !$past(select0_n_out)) else $error("ready rose outside a frame");
	a_slave_disable_ignored: assert property (port_enabled && !master_mode && disable_cmd
		&& !soft_reset_bit |=> port_enabled) else $error("slave disable took effect");
	a_hold_fault_blocks: assert property (hold_reg && !fdis_reg && select0_n_out
		|=> select0_n_out) else $error("transfer began with hold and fault check");
	a_disable_keeps_empty: assert property (port_enabled && master_mode && disable_cmd
		&& transmit_empty_flag && !tx_write && !dma_valid && !soft_reset_bit
		|=> transmit_empty_flag) else $error("disable changed empty flag");
	a_drop_tx_write: assert property (!port_enabled && tx_write && !enable_cmd
		&& !soft_reset_bit && transmit_empty_flag |=> transmit_empty_flag)
		else $error("write while disabled cleared empty flag");
	a_drop_dma_word: assert property (!port_enabled && dma_valid && !tx_write && !enable_cmd
		&& !soft_reset_bit |-> dma_ready ##1 $stable(transmit_empty_flag))
		else $error("dma word while disabled not dropped silently");
	a_slave_no_underrun: assert property (port_enabled && !master_mode && transmit_empty_flag
		&& !tx_write && !dma_valid && !soft_reset_bit |=> transmit_empty_flag)
		else $error("slave empty flag changed without a write");
	a_soft_reset_state: assert property (soft_reset_bit |=> !port_enabled && !master_mode
		&& transmit_empty_flag && !receive_ready_flag && select0_n_out && !clock_idle_polarity)
		else $error("soft reset left state behind");
endmodule : spi_port_checker

bind spi_port spi_port_checker chk (.clk, .reset_n, .enable_cmd, .disable_cmd, .soft_reset_bit,
	.mode_write, .mode_fault_check_disable_in, .select0_write, .hold_select_after_transfer_in,
	.tx_write, .dma_valid, .dma_ready, .receive_ready_flag, .transmit_empty_flag,
	.port_enabled, .master_mode, .clock_idle_polarity, .select0_n_out);

// ==== verif/spi_link_master.sv ====
// external serial master driving the slave pins
`timescale 1ns/10ps
module spi_link_master (
	// link pins
	output logic     link_clk,
	output logic     select_in_n,
	output logic     mosi_in,
	input wire logic miso_line
);
	logic [7:0] got; // word shifted back by the port
	// idle: clock still, select released
	initial begin
		link_clk = 1'h0;
		select_in_n = 1'h1;
		mosi_in = 1'h1;
	end
	// one frame msb first, data set while clock low
	task automatic frame(input logic [7:0] d);
		#3.3;
		select_in_n = 1'h0;
		for (int i = 7; i >= 0; i--) begin
			mosi_in = d[i];
			#7.5 link_clk = 1'h1;
			got = {got[6:0], miso_line};
			#7.5 link_clk = 1'h0;
		end
		#7.5 select_in_n = 1'h1;
		mosi_in = ~mosi_in; // released line does not keep last bit
	endtask : frame
	// select pulled low with the clock still and no data
	task automatic select_only(input int ns);
		select_in_n = 1'h0;
		#(ns);
		select_in_n = 1'h1;
	endtask : select_only
endmodule : spi_link_master

// ==== verif/tb.sv ====
// self-checking bench for the serial port
`timescale 1ns/10ps
module tb;
	logic       clk, reset_n, master_mode_in, mode_fault_check_disable_in, miso_in;
	logic       clock_idle_polarity_in, sample_phase_in, hold_select_after_transfer_in;
	logic       enable_cmd, disable_cmd, soft_reset_bit, mode_write, select0_write;
	logic       rx_read, tx_write, dma_valid, dma_ready, receive_ready_flag;
	logic       transmit_empty_flag, port_enabled, master_mode, clock_idle_polarity;
	logic       sck_out, select0_n_out, mosi_out, link_clk, select_in_n, mosi_in;
	logic       miso_slave_out, miso_oe_n, miso_line;
	logic [7:0] tx_data, dma_data, receive_holding_register;
	logic [6:0] stb; // one-hot strobes
	int         bad_count, checks, cycles;
	localparam logic [6:0] EN = 7'h01, DIS = 7'h02, SRST = 7'h04, MW = 7'h08;
	localparam logic [6:0] SW = 7'h10, RD = 7'h20, TXW = 7'h40;
	assign {tx_write, rx_read, select0_write, mode_write, soft_reset_bit, disable_cmd,
		enable_cmd} = stb;
	assign miso_line = miso_oe_n ? 1'h1 : miso_slave_out; // pulled up when released
	spi_port #(.SCK_HALF(1)) dut (
		.clk, .reset_n, .enable_cmd, .disable_cmd, .soft_reset_bit, .mode_write,
		.master_mode_in, .mode_fault_check_disable_in, .select0_write,
		.clock_idle_polarity_in, .sample_phase_in, .hold_select_after_transfer_in,
		.tx_write, .tx_data, .dma_valid, .dma_data, .dma_ready, .rx_read,
		.receive_holding_register, .receive_ready_flag, .transmit_empty_flag,
		.port_enabled, .master_mode, .clock_idle_polarity, .sck_out, .select0_n_out,
		.mosi_out, .miso_in, .link_clk, .select_in_n, .mosi_in, .miso_slave_out, .miso_oe_n
	);
	spi_link_master partner (.link_clk, .select_in_n, .mosi_in, .miso_line);
	////////////////////////////////
	// clock
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// one strobe cycle, driven at the falling edge
	task automatic strobe(input logic [6:0] s);
		@(negedge clk);
		stb = s;
		@(negedge clk);
		stb = 7'h00;
	endtask : strobe
	// compare and count
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// bounded wait for receive ready
	task automatic wait_ready();
		for (int i = 0; i < 40 && receive_ready_flag !== 1'h1; i++) @(negedge clk);
	endtask : wait_ready
	////////////////////////////////
	// writes while disabled are dropped
	task automatic t_disabled_writes();
		tx_data = 8'h11;
		strobe(TXW);
		chk("empty after tx write", 8'h01, transmit_empty_flag);
		dma_valid = 1'h1;
		dma_data = 8'h22;
		repeat (3) @(negedge clk);
		chk("dma ready", 8'h01, dma_ready);
		dma_valid = 1'h0;
		chk("empty after dma words", 8'h01, transmit_empty_flag);
	endtask : t_disabled_writes
	// master: hold with fault check hangs, then disable and soft reset
	task automatic t_master();
		master_mode_in = 1'h1;
		strobe(MW);
		hold_select_after_transfer_in = 1'h1;
		strobe(SW);
		strobe(EN);
		tx_data = 8'hA5;
		strobe(TXW);
		repeat (40) @(negedge clk);
		chk("select while hung", 8'h01, select0_n_out);
		chk("empty while hung", 8'h00, transmit_empty_flag);
		chk("sck idle while hung", 8'h00, sck_out);
		mode_fault_check_disable_in = 1'h1;
		strobe(MW);
		wait_ready();
		chk("master ready", 8'h01, receive_ready_flag);
		chk("master rx word", 8'hFF, receive_holding_register);
		strobe(DIS);
		chk("disabled", 8'h00, port_enabled);
		chk("empty kept set", 8'h01, transmit_empty_flag);
		strobe(EN);
		mode_fault_check_disable_in = 1'h0;
		strobe(MW);
		strobe(TXW);
		strobe(DIS);
		chk("empty kept clear", 8'h00, transmit_empty_flag);
		strobe(SRST);
		chk("soft reset empty", 8'h01, transmit_empty_flag);
		chk("soft reset mode", 8'h00, master_mode);
		chk("soft reset select", 8'h01, select0_n_out);
	endtask : t_master
	// master with dma: clean stop and resume of the channel
	task automatic t_dma_stop();
		strobe(MW);
		strobe(EN);
		dma_data = 8'h3C;
		dma_valid = 1'h1;
		@(negedge clk);
		dma_valid = 1'h0;
		@(negedge clk);
		chk("dma word select", 8'h00, select0_n_out);
		chk("dma word mosi msb", 8'h00, mosi_out);
		wait_ready();
		chk("dma word done", 8'h01, receive_ready_flag);
		chk("dma word rx", 8'hFF, receive_holding_register);
		repeat (2) @(negedge clk); // channel stopped, two idle slots
		strobe(DIS);
		chk("dma stop disabled", 8'h00, port_enabled);
		chk("dma stop empty", 8'h01, transmit_empty_flag);
		strobe(EN);
		strobe(RD);
		dma_valid = 1'h1;
		@(negedge clk);
		dma_valid = 1'h0;
		wait_ready();
		chk("dma resume ready", 8'h01, receive_ready_flag);
		strobe(SRST);
	endtask : t_dma_stop
	// slave: false ready cleared, word received, disable ignored
	task automatic t_slave();
		hold_select_after_transfer_in = 1'h0;
		strobe(SW);
		strobe(EN);
		partner.select_only(400);
		chk("false ready", 8'h01, receive_ready_flag);
		clock_idle_polarity_in = 1'h1;
		strobe(SW);
		chk("polarity away", 8'h01, clock_idle_polarity);
		clock_idle_polarity_in = 1'h0;
		strobe(SW);
		strobe(RD);
		chk("ready after clear", 8'h00, receive_ready_flag);
		tx_data = 8'hC3;
		strobe(TXW);
		partner.frame(8'h5A);
		wait_ready();
		chk("slave ready", 8'h01, receive_ready_flag);
		chk("slave rx word", 8'h5A, receive_holding_register);
		chk("slave empty", 8'h01, transmit_empty_flag);
		chk("slave tx word", 8'hC3, partner.got);
		strobe(DIS);
		chk("slave still on", 8'h01, port_enabled);
		strobe(RD);
		strobe(SRST);
		chk("slave stopped", 8'h00, port_enabled);
	endtask : t_slave
	////////////////////////////////
	// verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			report_and_stop();
		end
	end
	// main sequence
	initial begin
		{reset_n, master_mode_in, mode_fault_check_disable_in, miso_in} = 4'h1;
		{clock_idle_polarity_in, sample_phase_in, hold_select_after_transfer_in} = 3'h0;
		{dma_valid, stb, tx_data, dma_data} = 24'h0;
		{bad_count, checks, cycles} = 0;
		reset_n = 1'h0;
		repeat (8) @(negedge clk);
		reset_n = 1'h1;
		chk("reset enabled", 8'h00, port_enabled);
		chk("reset empty", 8'h01, transmit_empty_flag);
		chk("reset miso enable", 8'h01, miso_oe_n);
		t_disabled_writes();
		t_master();
		t_dma_stop();
		t_slave();
		report_and_stop();
	end
endmodule : tb
